// ### include/lsw_pkg.sv
package lsw_pkg;
  localparam int unsigned CLK_NS          = 40;
  localparam int unsigned TRIG_STABLE_US  = 2;
  localparam int unsigned TRIG_STABLE_CYC =
    (TRIG_STABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HIGH_STABLE_US  = 400;
  localparam int unsigned HIGH_STABLE_CYC =
    (HIGH_STABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TICK_US         = 1;
  localparam int unsigned TICK_CYC        = TICK_US * 1000 / CLK_NS;

  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_LIST_LEN = 4'h1;
  localparam logic [3:0] A_TIMEOUT  = 4'h2;
  localparam logic [3:0] A_WAIT_CMD = 4'h3;
  localparam logic [3:0] A_SETPOINT = 4'h4;
  localparam logic [3:0] A_VMAX     = 4'h5;
  localparam logic [3:0] A_VMIN     = 4'h6;
  localparam logic [3:0] A_LIM_SYM  = 4'h7;
  localparam logic [3:0] A_LIM_NEG  = 4'h8;
  localparam logic [3:0] A_LIM_POS  = 4'h9;
  localparam logic [3:0] A_ERROR    = 4'hA;
  localparam logic [3:0] A_STATUS   = 4'hB;

  localparam int unsigned CTRL_ABORT_BIT = 0;
  localparam int unsigned CTRL_SAVE_BIT  = 1;
  localparam int unsigned LEN_SP_LSB     = 0;
  localparam int unsigned LEN_DW_LSB     = 8;
  localparam int unsigned KIND_LSB       = 16;
  localparam int unsigned ERR_VALID_BIT  = 16;

  localparam logic [1:0] KIND_FALL = 2'h1;
  localparam logic [1:0] KIND_LOW  = 2'h2;
  localparam logic [1:0] KIND_HIGH = 2'h3;

  localparam logic [15:0] ERR_CONFLICT  = 16'hFF23;
  localparam logic [15:0] ERR_RANGE     = 16'hFF22;
  localparam logic [15:0] ERR_LEN_EDGE  = 16'hFF1E;
  localparam logic [15:0] ERR_LEN_LEVEL = 16'hFF14;

  localparam logic [15:0] VMAX_DEF   = 16'h03E8;
  localparam logic [15:0] VMIN_DEF   = 16'hFC18;
  localparam logic [15:0] VRATED_DEF = 16'h03E8;
endpackage

// ### hw/lsw_trig_filt.sv
`timescale 1ns/1ps
// Passes a level on only after it has held for STABLE_CYC cycles, so a
// glitch shorter than that never reaches the step logic.
module lsw_trig_filt #(
  parameter int unsigned STABLE_CYC = 50
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic lvl_in,
  output logic      lvl_out
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
  } lsw_filt_s;

  lsw_filt_s s_r;
  lsw_filt_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (lvl_in == s_r.lvl) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == LAST) begin
      s_nxt.lvl = lvl_in;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'h1;
    end
    // The line idles high, open circuit, so reset assumes high.
    if (!resetn) begin
      s_nxt.cnt = '0;
      s_nxt.lvl = 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign lvl_out = s_r.lvl;
endmodule

// ### hw/lsw_top.sv
`timescale 1ns/1ps
module lsw_top #(
  parameter logic [15:0] VMAX       = lsw_pkg::VMAX_DEF,
  parameter logic [15:0] VMIN       = lsw_pkg::VMIN_DEF,
  parameter logic [15:0] VRATED     = lsw_pkg::VRATED_DEF,
  parameter int unsigned HIGH_CYC   = lsw_pkg::HIGH_STABLE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        trig_in,
  input  wire logic        nv_valid,
  input  wire logic [15:0] nv_sym,
  input  wire logic [15:0] nv_neg,
  input  wire logic [15:0] nv_pos,
  output logic      [15:0] setpoint_out,
  output logic             step_adv,
  output logic             waiting,
  output logic             save_settings_cmd,
  output logic      [15:0] save_sym,
  output logic      [15:0] save_neg,
  output logic      [15:0] save_pos
);
  localparam int unsigned DW = $clog2(lsw_pkg::TICK_CYC);
  localparam logic [DW-1:0] DIV_LAST = DW'(lsw_pkg::TICK_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_ARM,
    S_FALL,
    S_LOW,
    S_HIGH
  } lsw_st_e;

  typedef struct packed {
    lsw_st_e       st;
    logic          sync1;
    logic          sync2;
    logic [15:0]   sp;
    logic [15:0]   vout;
    logic [15:0]   lim_sym;
    logic [15:0]   lim_neg;
    logic [15:0]   lim_pos;
    logic [7:0]    sp_len;
    logic [7:0]    dw_len;
    logic [15:0]   tmo;
    logic [15:0]   tcnt;
    logic [DW-1:0] div;
    logic [15:0]   err;
    logic          err_v;
    logic [31:0]   rdata;
    logic          adv;
    logic          save;
    logic          boot;
    logic          tmo_hit;
    logic          busy;
  } lsw_top_s;

  lsw_top_s s_r;
  lsw_top_s s_nxt;
  logic     lvl;
  logic     lvl_h;
  logic     tick;
  logic     tmo_exp;
  logic     done;
  logic     by_tmo;
  logic [1:0]  kind;
  logic [15:0] val;

  function automatic logic [15:0] umin(input logic [15:0] a,
                                       input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = ($signed(v) <= $signed(hi)) && ($signed(v) >= $signed(lo));
  endfunction

  // Clips a signed setpoint to the tighter positive and negative caps.
  // One bit of headroom keeps the negated cap from overflowing.
  function automatic logic [15:0] clip_sp(input logic [15:0] v,
                                          input logic [15:0] sym,
                                          input logic [15:0] neg,
                                          input logic [15:0] pos);
    logic [16:0] hi;
    logic [16:0] lo;
    logic [16:0] vx;
    hi = {1'h0, umin(sym, pos)};
    lo = 17'h00000 - {1'h0, umin(sym, neg)};
    vx = {v[15], v};
    if ($signed(vx) > $signed(hi)) begin
      clip_sp = hi[15:0];
    end else if ($signed(vx) < $signed(lo)) begin
      clip_sp = lo[15:0];
    end else begin
      clip_sp = v;
    end
  endfunction

  // Both filters see only the second synchroniser stage.
  lsw_trig_filt #(
    .STABLE_CYC (lsw_pkg::TRIG_STABLE_CYC)
  ) u_filt_fast (
    .mclk    (mclk),
    .resetn  (resetn),
    .lvl_in  (s_r.sync2),
    .lvl_out (lvl)
  );

  lsw_trig_filt #(
    .STABLE_CYC (HIGH_CYC)
  ) u_filt_high (
    .mclk    (mclk),
    .resetn  (resetn),
    .lvl_in  (s_r.sync2),
    .lvl_out (lvl_h)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.adv = 1'h0;
    s_nxt.save = 1'h0;
    s_nxt.boot = 1'h0;
    s_nxt.rdata = '0;
    s_nxt.sync1 = trig_in;
    s_nxt.sync2 = s_r.sync1;
    kind = wdata[lsw_pkg::KIND_LSB +: 2];
    val = wdata[15:0];
    done = 1'h0;
    by_tmo = 1'h0;

    // The timeout counts microsecond ticks from the step's own entry.
    tick = (s_r.div == DIV_LAST);
    s_nxt.div = tick ? '0 : s_r.div + 1'h1;
    tmo_exp = (s_r.tmo != 16'h0000) && (s_r.tcnt == s_r.tmo);
    // The count stops at the set value, so a timeout that has gone by
    // cannot wrap round and fire a second time.
    if (s_r.st != S_IDLE && tick && s_r.tcnt != s_r.tmo) begin
      s_nxt.tcnt = s_r.tcnt + 16'h0001;
    end

    // Restore saved limits once, in the first cycle after reset.
    if (s_r.boot && nv_valid) begin
      s_nxt.lim_sym = nv_sym;
      s_nxt.lim_neg = nv_neg;
      s_nxt.lim_pos = nv_pos;
    end

    unique case (s_r.st)
      S_IDLE: begin
      end
      S_ARM: begin
        // A level left low by the last step must be seen high first, so
        // it is never taken for a fresh edge.
        if (lvl) begin
          s_nxt.st = S_FALL;
        end
        by_tmo = tmo_exp;
      end
      S_FALL: begin
        done = !lvl;
        by_tmo = tmo_exp;
      end
      S_LOW: begin
        done = !lvl;
        by_tmo = tmo_exp;
      end
      S_HIGH: begin
        done = lvl_h;
        by_tmo = tmo_exp;
      end
    endcase
    if (done || by_tmo) begin
      s_nxt.st = S_IDLE;
      s_nxt.adv = 1'h1;
      s_nxt.tmo_hit = by_tmo && !done;
    end

    if (wr) begin
      unique case (addr)
        lsw_pkg::A_CTRL: begin
          // Abort drops the wait with no pulse, so no step is counted.
          if (wdata[lsw_pkg::CTRL_ABORT_BIT]) begin
            s_nxt.st = S_IDLE;
            s_nxt.adv = 1'h0;
          end
          if (wdata[lsw_pkg::CTRL_SAVE_BIT]) begin
            s_nxt.save = 1'h1;
          end
        end
        lsw_pkg::A_LIST_LEN: begin
          s_nxt.sp_len = wdata[lsw_pkg::LEN_SP_LSB +: 8];
          s_nxt.dw_len = wdata[lsw_pkg::LEN_DW_LSB +: 8];
        end
        lsw_pkg::A_TIMEOUT: begin
          s_nxt.tmo = val;
        end
        lsw_pkg::A_WAIT_CMD: begin
          if (s_r.st != S_IDLE || kind == 2'h0) begin
            s_nxt.err = lsw_pkg::ERR_CONFLICT;
            s_nxt.err_v = 1'h1;
          end else if (s_r.sp_len == 8'h00) begin
            s_nxt.err = lsw_pkg::ERR_CONFLICT;
            s_nxt.err_v = 1'h1;
          end else if (s_r.sp_len != s_r.dw_len) begin
            s_nxt.err = (kind == lsw_pkg::KIND_LOW) ?
                        lsw_pkg::ERR_LEN_LEVEL :
                        lsw_pkg::ERR_LEN_EDGE;
            s_nxt.err_v = 1'h1;
          end else if (!in_range(val, VMIN, VMAX)) begin
            s_nxt.err = lsw_pkg::ERR_RANGE;
            s_nxt.err_v = 1'h1;
          end else begin
            s_nxt.sp = val;
            s_nxt.tcnt = '0;
            s_nxt.div = '0;
            s_nxt.tmo_hit = 1'h0;
            s_nxt.adv = 1'h0;
            unique case (kind)
              lsw_pkg::KIND_FALL: begin
                s_nxt.st = lvl ? S_FALL : S_ARM;
              end
              lsw_pkg::KIND_LOW: begin
                // An input already low skips the step at once.
                s_nxt.st = lvl ? S_LOW : S_IDLE;
                s_nxt.adv = !lvl;
              end
              default: begin
                s_nxt.st = lvl_h ? S_IDLE : S_HIGH;
                s_nxt.adv = lvl_h;
              end
            endcase
          end
        end
        lsw_pkg::A_SETPOINT: begin
          if (s_r.st != S_IDLE) begin
            s_nxt.err = lsw_pkg::ERR_CONFLICT;
            s_nxt.err_v = 1'h1;
          end else if (!in_range(val, VMIN, VMAX)) begin
            s_nxt.err = lsw_pkg::ERR_RANGE;
            s_nxt.err_v = 1'h1;
          end else begin
            s_nxt.sp = val;
          end
        end
        lsw_pkg::A_LIM_SYM, lsw_pkg::A_LIM_NEG, lsw_pkg::A_LIM_POS: begin
          if (val > VRATED) begin
            s_nxt.err = lsw_pkg::ERR_RANGE;
            s_nxt.err_v = 1'h1;
          end else if (addr == lsw_pkg::A_LIM_SYM) begin
            s_nxt.lim_sym = val;
          end else if (addr == lsw_pkg::A_LIM_NEG) begin
            s_nxt.lim_neg = val;
          end else begin
            s_nxt.lim_pos = val;
          end
        end
        default: begin
        end
      endcase
    end

    if (rd) begin
      unique case (addr)
        lsw_pkg::A_LIST_LEN: begin
          s_nxt.rdata = {16'h0000, s_r.dw_len, s_r.sp_len};
        end
        lsw_pkg::A_TIMEOUT: begin
          s_nxt.rdata = {16'h0000, s_r.tmo};
        end
        lsw_pkg::A_SETPOINT: begin
          s_nxt.rdata = {16'h0000, s_r.sp};
        end
        lsw_pkg::A_VMAX: begin
          s_nxt.rdata = {16'h0000, VMAX};
        end
        lsw_pkg::A_VMIN: begin
          s_nxt.rdata = {16'h0000, VMIN};
        end
        lsw_pkg::A_LIM_SYM: begin
          s_nxt.rdata = {16'h0000, s_r.lim_sym};
        end
        lsw_pkg::A_LIM_NEG: begin
          s_nxt.rdata = {16'h0000, s_r.lim_neg};
        end
        lsw_pkg::A_LIM_POS: begin
          s_nxt.rdata = {16'h0000, s_r.lim_pos};
        end
        lsw_pkg::A_ERROR: begin
          // Reading clears the code unless a write comes in the same cycle. Only writes
          // raise errors, and one raised then keeps its code: the set wins over the clear.
          s_nxt.rdata = {15'h0000, s_r.err_v, s_r.err};
          if (!wr) begin
            s_nxt.err_v = 1'h0;
            s_nxt.err = 16'h0000;
          end
        end
        lsw_pkg::A_STATUS: begin
          s_nxt.rdata = {26'h0000000, s_r.tmo_hit, lvl_h, lvl,
                         s_r.st};
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // The output is the setpoint clipped to the tighter of the limits.
    s_nxt.vout = clip_sp(s_nxt.sp, s_nxt.lim_sym, s_nxt.lim_neg,
                         s_nxt.lim_pos);

    // Registered here so the wait flag reaches its pin from a flop.
    s_nxt.busy = (s_nxt.st != S_IDLE);

    if (!resetn) begin
      s_nxt = '0;
      s_nxt.st = S_IDLE;
      s_nxt.sync1 = 1'h1;
      s_nxt.sync2 = 1'h1;
      s_nxt.lim_sym = VRATED;
      s_nxt.lim_neg = VRATED;
      s_nxt.lim_pos = VRATED;
      s_nxt.boot = 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;
  assign setpoint_out = s_r.vout;
  assign step_adv = s_r.adv;
  assign waiting = s_r.busy;
  assign save_settings_cmd = s_r.save;
  assign save_sym = s_r.lim_sym;
  assign save_neg = s_r.lim_neg;
  assign save_pos = s_r.lim_pos;
endmodule

// ### sim/lsw_sva.sv
`timescale 1ns/1ps
module lsw_sva #(
  parameter logic [15:0] VMAX   = lsw_pkg::VMAX_DEF,
  parameter logic [15:0] VRATED = lsw_pkg::VRATED_DEF
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [15:0] setpoint_out,
  input wire logic        step_adv,
  input wire logic        waiting,
  input wire logic        save_settings_cmd,
  input wire logic [15:0] save_sym,
  input wire logic [15:0] save_neg,
  input wire logic [15:0] save_pos
);
  logic [15:0] mp;
  logic [15:0] mn;
  assign mp = (save_sym < save_pos) ? save_sym : save_pos;
  assign mn = (save_sym < save_neg) ? save_sym : save_neg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data seen outside its slot");
  a_vmax_read: assert property (rd && addr == lsw_pkg::A_VMAX
    |=> rdata == {16'h0, VMAX}) else $error("wrong maximum read");
  a_vmin_read: assert property (rd && addr == lsw_pkg::A_VMIN
    |=> rdata[31:16] == 16'h0 && $signed(rdata[15:0]) < 0)
    else $error("minimum read not negative");
  a_save_pulse: assert property (wr && addr == lsw_pkg::A_CTRL
    && wdata[1] |=> save_settings_cmd) else $error("no save pulse");
  a_pos_reject: assert property (wr && addr == lsw_pkg::A_LIM_POS
    && wdata > 32'(VRATED) |=> $stable(save_pos))
    else $error("oversize positive limit taken");
  a_sp_reject: assert property (wr && addr == lsw_pkg::A_SETPOINT
    && $signed(wdata[15:0]) > $signed(VMAX) |=> $stable(setpoint_out))
    else $error("oversize setpoint taken");
  a_busy_reject: assert property (wr && addr == lsw_pkg::A_WAIT_CMD
    && waiting |=> $stable(setpoint_out)) else $error("busy step taken");
  a_adv_cause: assert property (step_adv |-> !waiting
    && ($past(waiting) || $past(wr))) else $error("advance without step");
  a_sp_clip: assert property (($stable(save_sym) && $stable(save_neg)
    && $stable(save_pos))[*2] |-> $signed(setpoint_out) <= $signed(mp)
    && $signed(setpoint_out) >= -$signed(mn))
    else $error("setpoint outside limits");
endmodule
bind lsw_top lsw_sva #(.VMAX(VMAX), .VRATED(VRATED)) u_sva (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .setpoint_out(setpoint_out),
  .step_adv(step_adv), .waiting(waiting),
  .save_settings_cmd(save_settings_cmd), .save_sym(save_sym),
  .save_neg(save_neg), .save_pos(save_pos));

// ### sim/lsw_trig_drv.sv
`timescale 1ns/1ps
// HOLD is 2 us at 40 ns. A glt pulse breaks the hold time on purpose with
// a short low pulse, so the filter can be shown to swallow it.
module lsw_trig_drv #(
  parameter int HOLD = 50,
  parameter int GL   = 10
) (
  input  wire logic mclk,
  input  wire logic lvl,
  input  wire logic glt,
  output logic      trig_in
);
  logic lv_r  = 1'b1;
  int   cnt_r = 0;
  int   gl_r  = 0;
  assign trig_in = lv_r && (gl_r == 0);
  always @(posedge mclk) begin
    if (lvl != lv_r && cnt_r >= HOLD) begin
      lv_r  <= lvl;
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
    if (glt) begin
      gl_r <= GL;
    end else if (gl_r > 0) begin
      gl_r <= gl_r - 1;
    end
  end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic        mclk;
  logic        resetn;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        trig_in;
  logic        nv_valid;
  logic [15:0] nv_sym;
  logic [15:0] nv_neg;
  logic [15:0] nv_pos;
  logic [15:0] setpoint_out;
  logic        step_adv;
  logic        waiting;
  logic        save_settings_cmd;
  logic [15:0] save_sym;
  logic [15:0] save_neg;
  logic [15:0] save_pos;
  logic        lvl;
  logic        glt;
  logic [31:0] d;
  int          failures;
  int          cmp_count;
  lsw_top #(.HIGH_CYC(60)) u_dut (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .trig_in(trig_in), .nv_valid(nv_valid),
    .nv_sym(nv_sym), .nv_neg(nv_neg), .nv_pos(nv_pos),
    .setpoint_out(setpoint_out), .step_adv(step_adv), .waiting(waiting),
    .save_settings_cmd(save_settings_cmd), .save_sym(save_sym),
    .save_neg(save_neg), .save_pos(save_pos));
  lsw_trig_drv u_trig (.mclk(mclk), .lvl(lvl), .glt(glt),
    .trig_in(trig_in));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wreg(logic [3:0] a, logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(logic [3:0] a, logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
    `CHK(d, e)
  endtask
  task automatic quiet(int k);
    logic s;
    s = 1'b0;
    repeat (k) begin
      @(posedge mclk);
      #1 if (step_adv === 1'b1) s = 1'b1;
    end
    `CHK(s, 1'b0)
  endtask
  // Counts cycles to the advance pulse; giving up ends the run.
  task automatic wadv(int lo, int hi);
    int k;
    for (k = 0; k <= hi + 5; k++) begin
      #1 if (step_adv === 1'b1) break;
      @(posedge mclk);
    end
    if (k > hi + 5) begin
      failures++;
      end_sim;
    end
    `CHK(k >= lo && k <= hi, 1'b1)
    `CHK(waiting, 1'b0)
  endtask
  task automatic wstep(logic [1:0] k, logic [15:0] v, logic w);
    wreg(lsw_pkg::A_WAIT_CMD, {14'h0, k, v});
    #1 `CHK(setpoint_out, v)
    `CHK(waiting, w)
  endtask
  task automatic trig(logic v);
    @(posedge mclk);
    lvl <= v;
  endtask
  logic [3:0]  la [3] = '{lsw_pkg::A_LIM_SYM, lsw_pkg::A_LIM_NEG,
                          lsw_pkg::A_LIM_POS};
  logic [31:0] lv [3] = '{32'h190, 32'h12C, 32'hC8};
  logic [15:0] sv [3] = '{16'h0064, 16'h01F4, 16'hFE0C};
  logic [15:0] so [3] = '{16'h0064, 16'h00C8, 16'hFED4};
  logic [31:0] el [4] = '{32'h303, 32'h0, 32'h203, 32'h203};
  logic [31:0] ek [4] = '{32'h10, 32'h10010, 32'h10010, 32'h20010};
  logic [31:0] ee [4] = '{32'h1FF23, 32'h1FF23, 32'h1FF1E, 32'h1FF14};
  initial begin
    {resetn, wr, rd, glt, nv_valid} = 5'h0;
    {addr, wdata, nv_sym, nv_neg, nv_pos} = 84'h0;
    lvl = 1'b1;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rchk(lsw_pkg::A_LIM_SYM, 32'h3E8);
    rchk(lsw_pkg::A_VMAX, 32'h3E8);
    rchk(lsw_pkg::A_VMIN, 32'hFC18);
    rchk(4'hF, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wreg(la[i], lv[i]);
      rchk(la[i], lv[i]);
      wreg(la[i], 32'h3E9);
      rchk(lsw_pkg::A_ERROR, 32'h1FF22);
      rchk(la[i], lv[i]);
    end
    `CHK({save_sym, save_neg, save_pos}, 48'h019001_2C00C8)
    for (int i = 0; i < 3; i++) begin
      wreg(lsw_pkg::A_SETPOINT, {16'h0, sv[i]});
      #1 `CHK(setpoint_out, so[i])
    end
    rchk(lsw_pkg::A_SETPOINT, 32'hFE0C);
    wreg(lsw_pkg::A_SETPOINT, 32'h3E9);
    rchk(lsw_pkg::A_ERROR, 32'h1FF22);
    `CHK(setpoint_out, 16'hFED4)
    $display("test limits done");
    wreg(lsw_pkg::A_CTRL, 32'h2);
    #1 `CHK(save_settings_cmd, 1'b1)
    @(posedge mclk);
    {nv_sym, nv_neg, nv_pos} <= 48'h0190_012C_00C8;
    nv_valid <= 1'b1;
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rchk(lsw_pkg::A_LIM_NEG, 32'h12C);
    `CHK(setpoint_out, 16'h0)
    $display("test save done");
    for (int i = 0; i < 4; i++) begin
      wreg(lsw_pkg::A_LIST_LEN, el[i]);
      wreg(lsw_pkg::A_WAIT_CMD, ek[i]);
      rchk(lsw_pkg::A_ERROR, ee[i]);
    end
    wreg(lsw_pkg::A_LIST_LEN, 32'h303);
    wreg(lsw_pkg::A_TIMEOUT, 32'h0);
    $display("test errors done");
    wstep(2'h1, 16'h0032, 1'b1);
    quiet(300);
    wreg(lsw_pkg::A_WAIT_CMD, 32'h10040);
    rchk(lsw_pkg::A_ERROR, 32'h1FF23);
    @(posedge mclk) glt <= 1'b1;
    @(posedge mclk) glt <= 1'b0;
    quiet(200);
    trig(1'b0);
    wadv(50, 62);
    wstep(2'h1, 16'h0040, 1'b1);
    quiet(200);
    trig(1'b1);
    quiet(100);
    trig(1'b0);
    wadv(50, 62);
    $display("test edge done");
    wreg(lsw_pkg::A_TIMEOUT, 32'h5);
    wstep(2'h2, 16'h0048, 1'b0);
    wadv(0, 1);
    wreg(lsw_pkg::A_TIMEOUT, 32'h0);
    trig(1'b1);
    repeat (80) @(posedge mclk);
    wstep(2'h2, 16'h0050, 1'b1);
    quiet(300);
    trig(1'b0);
    wadv(50, 62);
    $display("test level done");
    wreg(lsw_pkg::A_TIMEOUT, 32'h4);
    trig(1'b1);
    repeat (80) @(posedge mclk);
    for (int k = 1; k < 3; k++) begin
      wstep(k[1:0], 16'h0020, 1'b1);
      wadv(98, 104);
      rchk(lsw_pkg::A_STATUS, 32'h38);
      `CHK(d[5], 1'b1)
    end
    $display("test timeout done");
    wreg(lsw_pkg::A_TIMEOUT, 32'h0);
    trig(1'b0);
    repeat (90) @(posedge mclk);
    wstep(2'h3, 16'h0030, 1'b1);
    quiet(50);
    trig(1'b1);
    wadv(60, 72);
    $display("test high done");
    end_sim;
  end
endmodule
